// ### common/iqf_pkg.sv
// Constants, register map and types for the interpolating IQ FIR stage.
// Assumes an APB slave with 32-bit data on the sample clock.
package iqf_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [11:0] IQF_CTRL_OFS = 12'h000;
    localparam logic [11:0] IQF_CIC_OFS = 12'h004;
    localparam logic [11:0] IQF_STAT_OFS = 12'h008;
    localparam logic [11:0] IQF_IRQEN_OFS = 12'h00C;
    localparam logic [11:0] IQF_IRQCLR_OFS = 12'h010;
    localparam logic [11:0] IQF_CUR_OFS = 12'h014;
    localparam logic [11:0] IQF_COEF_OFS = 12'h400;
    // ****************************************
    // Fields
    // ****************************************
    localparam int IQF_CTRL_EN = 0;
    localparam int IQF_CTRL_REP = 1;
    localparam int IQF_CTRL_FACT_LO = 2;
    localparam int IQF_CTRL_GO = 4;
    localparam int IQF_CTRL_GAINCHG = 5;
    localparam int IQF_STAT_OVF = 0;
    localparam int IQF_STAT_START = 1;
    localparam int IQF_NUM_EVT = 2;
    localparam logic [31:0] IQF_CTRL_RST = 32'h0000_0002;
    localparam logic [7:0] IQF_CIC_RST = 8'h06;
    localparam int IQF_SUPPRESS_SAMPLES = 50;
    localparam int IQF_NUM_TAPS = 95;
    localparam int IQF_NUM_COEF = (IQF_NUM_TAPS + 1) / 2;
    typedef enum logic [1:0] {
        IQF_X2 = 2'b00,
        IQF_X4 = 2'b01,
        IQF_X8 = 2'b10
    } iqf_fact_type;
    typedef enum logic [1:0] {
        IQF_IDLE = 2'b00,
        IQF_CLEAR = 2'b01,
        IQF_RUN = 2'b10
    } iqf_state_type;
endpackage

// ### rtl/iqf_tap_mac.sv
// Symmetric multiply-accumulate over one delay line, one coefficient pair per clock.
// Assumes coefficient index supplied by the caller; sum is full precision.
`timescale 1ns/1ps
`default_nettype none
module iqf_tap_mac #(
    parameter int DW = 16,
    parameter int CW = 18,
    parameter int AW = 48
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clr,
    input wire logic acc,
    input wire logic signed [DW-1:0] tapA,
    input wire logic signed [DW-1:0] tapB,
    input wire logic pairOnly,
    input wire logic signed [CW-1:0] coef,
    output logic signed [AW-1:0] sum
);
    logic signed [DW:0] preAdd;
    logic signed [AW-1:0] prod;
    // Pre-add mirrored taps; centre tap counted once
    always_comb begin
        preAdd = pairOnly ? DW'(0) + tapA : tapA + tapB;
        prod = AW'(preAdd * coef);
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sum <= '0;
        end else if (clr) begin
            sum <= '0;
        end else if (acc) begin
            sum <= sum + prod;
        end
    end
endmodule
`default_nettype wire

// ### rtl/iqf_fir.sv
// Interpolating symmetric IQ FIR with APB registers and overflow reporting.
// Assumes upstream samples arrive on the sample clock; outputs feed a CIC.
`timescale 1ns/1ps
`default_nettype none
module iqf_fir
    import iqf_pkg::*;
#(
    parameter int DW = 16,
    parameter int CW = 18,
    parameter int TAPS = IQF_NUM_TAPS
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [DW-1:0] inI,
    input wire logic signed [DW-1:0] inQ,
    output logic inTake,
    output logic signed [DW-1:0] outI,
    output logic signed [DW-1:0] outQ,
    output logic outValid,
    output logic filtEnable,
    output logic irq
);
    localparam int NC = (TAPS + 1) / 2;
    localparam int AW = DW + CW + 8;
    localparam int CIX = $clog2(NC);
    initial begin
        if (TAPS % 2 != 1 || DW < 4 || CW < 4 || CW > 32) begin
            $error("iqf_fir: unsupported parameters");
        end
    end
    // ****************************************
    // Registers
    // ****************************************
    logic [31:0] ctrl_ff;
    logic [7:0] cicFact_ff;
    logic [IQF_NUM_EVT-1:0] stat_ff;
    logic [IQF_NUM_EVT-1:0] irqEn_ff;
    logic signed [CW-1:0] coef_ff [NC];
    logic wrEn;
    logic rdEn;
    logic coefHit;
    logic [9:0] coefIdx;
    logic goPulse;
    logic chgPulse;
    logic ovfEvt;
    logic [IQF_NUM_EVT-1:0] evtSet;
    logic [IQF_NUM_EVT-1:0] clrMask;
    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && penable && !pwrite;
    assign coefIdx = 10'((paddr - IQF_COEF_OFS) >> 2);
    assign coefHit = paddr >= IQF_COEF_OFS && coefIdx < 10'(NC);
    assign goPulse = wrEn && paddr == IQF_CTRL_OFS && pwdata[IQF_CTRL_GO];
    assign chgPulse = wrEn && paddr == IQF_CTRL_OFS && pwdata[IQF_CTRL_GAINCHG];
    assign clrMask = (wrEn && paddr == IQF_IRQCLR_OFS) ? pwdata[IQF_NUM_EVT-1:0] : '0;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff <= IQF_CTRL_RST;
            cicFact_ff <= IQF_CIC_RST;
            irqEn_ff <= '0;
        end else if (wrEn) begin
            // Go and change bits are strobes, never stored
            if (paddr == IQF_CTRL_OFS) begin
                ctrl_ff <= {26'h000_0000, 2'b00, pwdata[3:0]};
            end
            if (paddr == IQF_CIC_OFS) begin
                cicFact_ff <= pwdata[7:0];
            end
            if (paddr == IQF_IRQEN_OFS) begin
                irqEn_ff <= pwdata[IQF_NUM_EVT-1:0];
            end
        end
    end
    // Coefficient store, one word per shared value
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int k = 0; k < NC; k++) begin
                coef_ff[k] <= '0;
            end
        end else if (wrEn && coefHit) begin
            coef_ff[coefIdx[CIX-1:0]] <= pwdata[CW-1:0];
        end
    end
    // Sticky status: set wins over clear
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            stat_ff <= '0;
        end else begin
            stat_ff <= (stat_ff & ~clrMask) | evtSet;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((stat_ff & ~clrMask) | evtSet) & irqEn_ff);
        end
    end
    // ****************************************
    // APB read path, zero wait states
    // ****************************************
    logic [31:0] rdVal;
    logic [7:0] supCnt_ff;
    iqf_state_type state_ff;
    always_comb begin
        rdVal = 32'h0000_0000;
        if (coefHit) begin
            rdVal = 32'(coef_ff[coefIdx[CIX-1:0]]);
        end else begin
            case (paddr)
                IQF_CTRL_OFS: rdVal = ctrl_ff;
                IQF_CIC_OFS: rdVal = {24'h00_0000, cicFact_ff};
                IQF_STAT_OFS: rdVal = 32'(stat_ff);
                IQF_IRQEN_OFS: rdVal = 32'(irqEn_ff);
                IQF_CUR_OFS: rdVal = {22'h00_0000, state_ff, supCnt_ff};
                default: rdVal = 32'h0000_0000;
            endcase
        end
    end
    logic mapped;
    assign mapped = coefHit || paddr inside {IQF_CTRL_OFS, IQF_CIC_OFS, IQF_STAT_OFS,
        IQF_IRQEN_OFS, IQF_IRQCLR_OFS, IQF_CUR_OFS};
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && !pwrite) ? rdVal : prdata;
        end
    end
    // ****************************************
    // Sample pacing and generation control
    // ****************************************
    logic [3:0] firFact;
    logic [11:0] period;
    logic [11:0] paceCnt_ff;
    logic [6:0] clrIdx_ff;
    logic [3:0] phase_ff;
    logic [7:0] macIdx_ff;
    logic signed [DW-1:0] lineI_ff [TAPS];
    logic signed [DW-1:0] lineQ_ff [TAPS];
    logic takeNow;
    always_comb begin
        case (iqf_fact_type'(ctrl_ff[IQF_CTRL_FACT_LO +: 2]))
            IQF_X2: firFact = 4'd2;
            IQF_X4: firFact = 4'd4;
            IQF_X8: firFact = 4'd8;
            default: firFact = 4'd2;
        endcase
        period = 12'(firFact * cicFact_ff);
    end
    assign filtEnable = ctrl_ff[IQF_CTRL_EN];
    assign takeNow = state_ff == IQF_RUN && paceCnt_ff == 12'd0;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= IQF_IDLE;
            clrIdx_ff <= '0;
        end else begin
            case (state_ff)
                IQF_IDLE: if (goPulse) begin
                    state_ff <= IQF_CLEAR;
                    clrIdx_ff <= '0;
                end
                IQF_CLEAR: begin
                    clrIdx_ff <= clrIdx_ff + 7'd1;
                    if (clrIdx_ff == 7'(TAPS - 1)) begin
                        state_ff <= IQF_RUN;
                    end
                end
                IQF_RUN: if (goPulse) begin
                    state_ff <= IQF_CLEAR;
                    clrIdx_ff <= '0;
                end else if (!filtEnable) begin
                    state_ff <= IQF_IDLE;
                end
                default: state_ff <= IQF_IDLE;
            endcase
        end
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            paceCnt_ff <= '0;
            inTake <= 1'b0;
        end else begin
            inTake <= takeNow;
            if (state_ff != IQF_RUN || paceCnt_ff == period - 12'd1) begin
                paceCnt_ff <= '0;
            end else begin
                paceCnt_ff <= paceCnt_ff + 12'd1;
            end
        end
    end
    // Delay line; clearing one tap per clock keeps the write port narrow
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int k = 0; k < TAPS; k++) begin
                lineI_ff[k] <= '0;
                lineQ_ff[k] <= '0;
            end
        end else if (state_ff == IQF_CLEAR) begin
            lineI_ff[clrIdx_ff] <= '0;
            lineQ_ff[clrIdx_ff] <= '0;
        end else if (takeNow) begin
            lineI_ff[0] <= inI;
            lineQ_ff[0] <= inQ;
            for (int k = 1; k < TAPS; k++) begin
                lineI_ff[k] <= lineI_ff[k-1];
                lineQ_ff[k] <= lineQ_ff[k-1];
            end
        end
    end
    // ****************************************
    // Polyphase MAC: one output phase per slot
    // ****************************************
    logic [11:0] slot;
    logic slotStart;
    logic macRun;
    logic macLast;
    logic [6:0] tapHi;
    assign slot = 12'(period / 12'(firFact));
    assign slotStart = state_ff == IQF_RUN && paceCnt_ff % slot == 12'd0;
    assign macRun = macIdx_ff < 8'(NC);
    assign macLast = macIdx_ff == 8'(NC - 1);
    assign tapHi = 7'(TAPS - 1) - 7'(macIdx_ff);
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            macIdx_ff <= 8'(NC);
            phase_ff <= '0;
        end else if (slotStart) begin
            macIdx_ff <= '0;
            phase_ff <= takeNow ? 4'd0 : phase_ff + 4'd1;
        end else if (macRun) begin
            macIdx_ff <= macIdx_ff + 8'd1;
        end
    end
    // Every phase sums all taps: phase_ff does not gate taps or coefficients
    logic signed [DW-1:0] aI, bI, aQ, bQ;
    logic pairOnly;
    logic signed [CW-1:0] cSel;
    logic signed [AW-1:0] sumI, sumQ;
    always_comb begin
        pairOnly = macIdx_ff == 8'(NC - 1);
        cSel = macRun ? coef_ff[macIdx_ff[CIX-1:0]] : '0;
        aI = lineI_ff[macIdx_ff[6:0] < 7'(TAPS) ? macIdx_ff[6:0] : 7'd0];
        bI = lineI_ff[tapHi];
        aQ = lineQ_ff[macIdx_ff[6:0] < 7'(TAPS) ? macIdx_ff[6:0] : 7'd0];
        bQ = lineQ_ff[tapHi];
    end
    iqf_tap_mac #(.DW(DW), .CW(CW), .AW(AW)) uMacI (
        .clk_sys(clk_sys), .rst_b(rst_b), .clr(slotStart), .acc(macRun),
        .tapA(aI), .tapB(bI), .pairOnly(pairOnly), .coef(cSel), .sum(sumI)
    );
    iqf_tap_mac #(.DW(DW), .CW(CW), .AW(AW)) uMacQ (
        .clk_sys(clk_sys), .rst_b(rst_b), .clr(slotStart), .acc(macRun),
        .tapA(aQ), .tapB(bQ), .pairOnly(pairOnly), .coef(cSel), .sum(sumQ)
    );
    // ****************************************
    // Scaling, saturation and overflow
    // ****************************************
    // Coefficient full scale is 2^(CW-1): shifting back keeps unity gain
    localparam logic signed [AW-1:0] POS_FS = AW'((2 ** (DW - 1)) - 1) <<< (CW - 1);
    localparam logic signed [AW-1:0] NEG_FS = -(AW'(2 ** (DW - 1)) <<< (CW - 1));
    logic macDone_ff;
    logic ovfI, ovfQ;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            macDone_ff <= 1'b0;
        end else begin
            macDone_ff <= macLast;
        end
    end
    assign ovfI = sumI > POS_FS || sumI < NEG_FS;
    assign ovfQ = sumQ > POS_FS || sumQ < NEG_FS;
    function automatic logic signed [DW-1:0] sat(input logic signed [AW-1:0] s);
        if (s > POS_FS) begin
            return {1'b0, {(DW-1){1'b1}}};
        end else if (s < NEG_FS) begin
            return {1'b1, {(DW-1){1'b0}}};
        end
        return DW'(s >>> (CW - 1));
    endfunction
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            outI <= '0;
            outQ <= '0;
            outValid <= 1'b0;
        end else begin
            outValid <= macDone_ff;
            if (macDone_ff) begin
                outI <= sat(sumI);
                outQ <= sat(sumQ);
            end
        end
    end
    // Window counts IQ input samples; a go or gain-change strobe restarts it
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            supCnt_ff <= '0;
        end else if (goPulse || chgPulse) begin
            supCnt_ff <= 8'(IQF_SUPPRESS_SAMPLES);
        end else if (takeNow && supCnt_ff != 8'd0) begin
            supCnt_ff <= supCnt_ff - 8'd1;
        end
    end
    assign ovfEvt = macDone_ff && (ovfI || ovfQ) && supCnt_ff == 8'd0
        && ctrl_ff[IQF_CTRL_REP];
    assign evtSet = {goPulse, ovfEvt};
endmodule
`default_nettype wire

// ### dv/iqf_fir_checker.sv
// Port checker for the interpolating IQ FIR: bus timing and stream pacing.
// Assumes it is bound to iqf_fir; control writes are shadowed from the bus.
`timescale 1ns/1ps
`default_nettype none
module iqf_fir_checker
    import iqf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic inTake,
    input wire logic outValid,
    input wire logic filtEnable
);
    // ****************
    // Helper state
    // ****************
    logic enSh_ff;
    logic [1:0] fact_ff;
    logic [7:0] cic_ff;
    logic [1:0] seen_ff;
    logic [15:0] gap_ff;
    logic [3:0] outCnt_ff;
    logic wrDone;
    logic mapped;
    logic [15:0] period;
    assign wrDone = psel && penable && pready && pwrite && !pslverr;
    assign mapped = (paddr < 12'h018) || (paddr >= IQF_COEF_OFS && paddr < 12'h4C0);
    assign period = 16'(cic_ff) << (fact_ff + 2'd1);
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            enSh_ff <= 1'b0;
            fact_ff <= 2'd0;
            cic_ff <= IQF_CIC_RST;
        end else if (wrDone && paddr == IQF_CTRL_OFS) begin
            enSh_ff <= pwdata[IQF_CTRL_EN];
            fact_ff <= pwdata[3:2];
        end else if (wrDone && paddr == IQF_CIC_OFS) begin
            cic_ff <= pwdata[7:0];
        end
    end
    // Any write without pslverr restarts pacing checks; first interval may be partial
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            seen_ff <= 2'd0;
            gap_ff <= 16'd0;
            outCnt_ff <= 4'd0;
        end else begin
            gap_ff <= inTake ? 16'd1 : gap_ff + 16'd1;
            outCnt_ff <= inTake ? 4'(outValid) : outCnt_ff + 4'(outValid);
            if (wrDone)
                seen_ff <= 2'd0;
            else if (inTake && seen_ff != 2'd3)
                seen_ff <= seen_ff + 2'd1;
        end
    end
    // ****************
    // Assertions
    // ****************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    property p_rdy; pready |-> psel && penable; endproperty
    a_rdy: assert property (p_rdy) else $error("pready outside access");
    property p_ans; psel && !penable |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("no answer in access");
    property p_err; pready |-> pslverr == !mapped; endproperty
    a_err: assert property (p_err) else $error("pslverr wrong");
    property p_en; filtEnable == enSh_ff; endproperty
    a_en: assert property (p_en) else $error("enable differs");
    property p_gap; inTake && seen_ff != 2'd0 |-> gap_ff == period; endproperty
    a_gap: assert property (p_gap) else $error("take spacing");
    property p_outs; inTake && seen_ff[1] |-> outCnt_ff == 4'(2 << fact_ff); endproperty
    a_outs: assert property (p_outs) else $error("outputs per input");
    property p_take; inTake |=> !inTake; endproperty
    a_take: assert property (p_take) else $error("take not a pulse");
    property p_out; outValid |=> !outValid; endproperty
    a_out: assert property (p_out) else $error("valid not a pulse");
endmodule
bind iqf_fir iqf_fir_checker i_chk (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .inTake, .outValid, .filtEnable);
`default_nettype wire

// ### dv/iqf_stream_model.sv
// Upstream sample source and downstream CIC sink for the IQ FIR.
// Assumes the bench sets the held level between generations only.
`timescale 1ns/1ps
`default_nettype none
module iqf_stream_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic signed [15:0] level,
    input wire logic inTake,
    input wire logic outValid,
    input wire logic signed [15:0] outI,
    input wire logic signed [15:0] outQ,
    output logic signed [15:0] inI,
    output logic signed [15:0] inQ,
    output logic [31:0] takes_ff,
    output logic [31:0] outs_ff,
    output logic [31:0] nzOuts_ff,
    output logic signed [15:0] lastI_ff,
    output logic signed [15:0] lastQ_ff
);
    // Q mirrors I so both rails are exercised
    assign inI = level;
    assign inQ = -level;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            takes_ff <= '0;
            outs_ff <= '0;
            nzOuts_ff <= '0;
            lastI_ff <= '0;
            lastQ_ff <= '0;
        end else begin
            takes_ff <= takes_ff + 32'(inTake);
            if (outValid) begin
                outs_ff <= outs_ff + 32'd1;
                nzOuts_ff <= nzOuts_ff + 32'(outI != 0 || outQ != 0);
                lastI_ff <= outI;
                lastQ_ff <= outQ;
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/test_iq_interpolating_fir.sv
// Self-checking bench for the interpolating IQ FIR over APB.
// Assumes the stream model feeds samples and counts outputs.
`timescale 1ns/1ps
`default_nettype none
module test_iq_interpolating_fir
    import iqf_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd, mark, nz0, takes_ff, outs_ff, nzOuts_ff;
    logic pready, pslverr, inTake, outValid, filtEnable, irq, err;
    logic signed [15:0] level = '0;
    logic signed [15:0] inI, inQ, outI, outQ, lastI_ff, lastQ_ff;
    int errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    time t0;
    iqf_fir i_dut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .inI, .inQ, .inTake, .outI, .outQ, .outValid, .filtEnable, .irq);
    iqf_stream_model i_src (.clk_sys, .rst_b, .level, .inTake, .outValid, .outI, .outQ,
        .inI, .inQ, .takes_ff, .outs_ff, .nzOuts_ff, .lastI_ff, .lastQ_ff);
    always #5 clk_sys = ~clk_sys;
    // ****************
    // Tasks
    // ****************
    task automatic final_report();
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            final_report();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, '0);
        check(rd & m, e);
    endtask
    // Overall timeout bounds this wait
    task automatic takes_wait(input int n);
        mark = takes_ff + 32'(n);
        while (takes_ff < mark) @(posedge clk_sys);
    endtask
    // ****************
    // Main sequence
    // ****************
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        rdc(IQF_CTRL_OFS, '1, IQF_CTRL_RST);
        rdc(IQF_CIC_OFS, '1, 32'(IQF_CIC_RST));
        apb(1'b0, 12'h020, '0);
        check(rd, '0);
        check(32'(err), 32'h0000_0001);
        for (int k = 0; k < IQF_NUM_COEF; k++)
            wr(IQF_COEF_OFS + 12'(4 * k), 32'h0001_FFFF);
        wr(IQF_COEF_OFS + 12'h004, 32'h0002_0001);
        rdc(IQF_COEF_OFS + 12'h004, 32'h0003_FFFF, 32'h0002_0001);
        rdc(IQF_COEF_OFS + 12'h0BC, 32'h0003_FFFF, 32'h0001_FFFF);
        level <= 16'sh7FFF;
        wr(IQF_CIC_OFS, 32'd49);
        wr(IQF_IRQEN_OFS, 32'h0000_0003);
        wr(IQF_CTRL_OFS, 32'h0000_0013);
        takes_wait(40);
        rdc(IQF_STAT_OFS, 32'h1, 32'h0);
        check({lastQ_ff, lastI_ff}, 32'h8000_7FFF);
        check(32'(irq), 32'h1);
        takes_wait(20);
        rdc(IQF_STAT_OFS, 32'h1, 32'h1);
        wr(IQF_IRQEN_OFS, 32'h0);
        repeat (2) @(posedge clk_sys);
        check(32'(irq), 32'h0);
        wr(IQF_IRQEN_OFS, 32'h3);
        wr(IQF_IRQCLR_OFS, 32'h3);
        rdc(IQF_STAT_OFS, 32'h2, 32'h0);
        wr(IQF_CTRL_OFS, 32'h0000_0023);
        wr(IQF_IRQCLR_OFS, 32'h1);
        takes_wait(30);
        rdc(IQF_STAT_OFS, 32'h1, 32'h0);
        check(32'(irq), 32'h0);
        takes_wait(30);
        rdc(IQF_STAT_OFS, 32'h1, 32'h1);
        wr(IQF_CTRL_OFS, 32'h0000_0011);
        wr(IQF_IRQCLR_OFS, 32'h3);
        takes_wait(80);
        rdc(IQF_STAT_OFS, 32'h1, 32'h0);
        check({lastQ_ff, lastI_ff}, 32'h8000_7FFF);
        level <= 16'sh0000;
        wr(IQF_CTRL_OFS, 32'h0000_0013);
        takes_wait(1);
        nz0 = nzOuts_ff;
        takes_wait(10);
        check(nzOuts_ff, nz0);
        for (int f = 0; f < 3; f++) begin
            wr(IQF_CTRL_OFS, 32'h13 | 32'(f << 2));
            takes_wait(3);
            nz0 = outs_ff;
            t0 = $time;
            takes_wait(4);
            check(outs_ff - nz0, 32'(8 << f));
            check(32'(($time - t0) / 10), 32'(196 * (2 << f)));
        end
        // Centre plus one pair summing to exactly one: full scale must pass untouched
        for (int k = 0; k < IQF_NUM_COEF; k++)
            wr(IQF_COEF_OFS + 12'(4 * k), 32'h0000_0000);
        wr(IQF_COEF_OFS + 12'h0BC, 32'h0001_0000);
        wr(IQF_COEF_OFS + 12'h0B8, 32'h0000_8000);
        level <= 16'sh7FFF;
        wr(IQF_CTRL_OFS, 32'h0000_0013);
        takes_wait(60);
        check({lastQ_ff, lastI_ff}, 32'h8001_7FFF);
        rdc(IQF_STAT_OFS, 32'h1, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
